//--- verilog/isd_defines.svh
`ifndef ISD_DEFINES_SVH
`define ISD_DEFINES_SVH

// Register offsets on the plain register port
`define ISD_OFF_CTRL 8'h00
`define ISD_OFF_LINK 8'h04
`define ISD_OFF_STATUS 8'h08
`define ISD_OFF_DISPLAY 8'h0C
`define ISD_OFF_PGRATE 8'h10

// Control register fields and reset values
`define ISD_CTRL_SCOPE_LSB 0
`define ISD_CTRL_HEXOUT_BIT 2
`define ISD_SCOPE_RESET 2'h0
`define ISD_HEXOUT_RESET 1'b0
`define ISD_LINK_RESET 16'h0000

// Menu scope value that opens the full menu
`define ISD_SCOPE_FULL 2'h2

// Menu numbers on the function selection menu
`define ISD_MENU_FUNC 3'h0
`define ISD_MENU_IO 3'h4

// Check item codes as shown on the list page
`define ISD_CODE_TERM 8'h00
`define ISD_CODE_LINK 8'h01
`define ISD_CODE_PG 8'h15
`define ISD_MENU_GLYPH_HI 4'h4

// Link command bits that carry a terminal; the rest are cleared
`define ISD_LINK_MASK 16'hE07F

// Pulse rate scale for the encoder readout
`define ISD_PG_DIVISOR 24'h0003E8
`define ISD_PG_MAX 24'h00FFFF

// Segment patterns, bit 0 = a ... bit 6 = g, bit 7 = dp
`define ISD_SEG_DASH 8'h40
`define ISD_SEG_UNDER 8'h08
`define ISD_SEG_BLANK 8'h00
`define ISD_GLYPH_0 8'h3F
`define ISD_GLYPH_1 8'h06
`define ISD_GLYPH_2 8'h5B
`define ISD_GLYPH_3 8'h4F
`define ISD_GLYPH_4 8'h66
`define ISD_GLYPH_5 8'h6D
`define ISD_GLYPH_6 8'h7D
`define ISD_GLYPH_7 8'h07
`define ISD_GLYPH_8 8'h7F
`define ISD_GLYPH_9 8'h6F
`define ISD_GLYPH_A 8'h77
`define ISD_GLYPH_B 8'h7C
`define ISD_GLYPH_C 8'h39
`define ISD_GLYPH_D 8'h5E
`define ISD_GLYPH_E 8'h79
`define ISD_GLYPH_F 8'h71

`endif

//--- verilog/isd_pkg.sv
package isd_pkg;

    // Operator menu position, Gray coded along run-menu-list-data
    typedef enum logic [1:0] {
        ST_RUN = 2'h0,
        ST_MENU = 2'h1,
        ST_LIST = 2'h3,
        ST_DATA = 2'h2
    } isd_state_t;

    // Check items on the I/O checking list
    typedef enum logic [1:0] {
        IT_TERM = 2'h0,
        IT_LINK = 2'h1,
        IT_PG = 2'h2
    } isd_item_t;

    // Control terminal states, 1 = circuit closed
    typedef struct packed {
        logic relay_contact_output;
        logic transistor_output_2;
        logic transistor_output_1;
        logic general_input_5;
        logic general_input_4;
        logic general_input_3;
        logic general_input_2;
        logic general_input_1;
        logic reverse_run_input;
        logic forward_run_input;
    } isd_term_t;

    // Operator keys, 1 = pressed
    typedef struct packed {
        logic prog;
        logic up;
        logic down;
        logic func;
    } isd_keys_t;

    // Four digits, digit4 leftmost
    typedef struct packed {
        logic [7:0] digit4;
        logic [7:0] digit3;
        logic [7:0] digit2;
        logic [7:0] digit1;
    } isd_disp_t;

endpackage

//--- verilog/isd_glyph.sv
`timescale 1ns/100ps
`include "isd_defines.svh"

module isd_glyph (
    input wire logic [3:0] nibble,
    output logic [7:0] segs
);
    // One hex digit to its seven-segment pattern
    always_comb begin
        unique case (nibble)
            4'h0: segs = `ISD_GLYPH_0;
            4'h1: segs = `ISD_GLYPH_1;
            4'h2: segs = `ISD_GLYPH_2;
            4'h3: segs = `ISD_GLYPH_3;
            4'h4: segs = `ISD_GLYPH_4;
            4'h5: segs = `ISD_GLYPH_5;
            4'h6: segs = `ISD_GLYPH_6;
            4'h7: segs = `ISD_GLYPH_7;
            4'h8: segs = `ISD_GLYPH_8;
            4'h9: segs = `ISD_GLYPH_9;
            4'hA: segs = `ISD_GLYPH_A;
            4'hB: segs = `ISD_GLYPH_B;
            4'hC: segs = `ISD_GLYPH_C;
            4'hD: segs = `ISD_GLYPH_D;
            4'hE: segs = `ISD_GLYPH_E;
            4'hF: segs = `ISD_GLYPH_F;
        endcase
    end

endmodule

//--- verilog/isd_display.sv
// Operation
// - Each four-bit group of a word shows as one hex glyph 0 to F.
// - Segment mode: rightmost digit a..g follow forward, reverse, five general inputs.
// - Segment mode: third digit a and b follow the two transistor outputs.
// - Segment mode: leftmost digit a follows the relay contact.
// - Segment mode, all inputs off: segment g lights on all four digits.
// - Up or down key toggles segment and hex display on both terminal items.
// - Link item shows the commanded word in place of the physical inputs; the outputs stay physical.
// - I/O checking menu reachable only when menu scope holds 2.
// - Encoder A/B item shows pulse rate divided by 1000.
// - Start in running mode; program key opens the function selection menu.
// - Hex inputs: forward bit 0, reverse bit 1, general inputs bits 2 to 6.
// - Hex outputs: transistor outputs bits 0 and 1, relay bit 8.
`timescale 1ns/100ps
`include "isd_defines.svh"

module isd_display (
    input wire logic clk,
    input wire logic rst_n,
    input wire isd_pkg::isd_term_t term_pins,
    input wire isd_pkg::isd_keys_t key_pins,
    input wire logic [23:0] pulse_generator_feedback_rate,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output isd_pkg::isd_disp_t led
);
    import isd_pkg::*;

    // Pin synchronisers; key history reads only the second stage
    logic [13:0] pin_meta_ff, nxt_pin_meta;
    logic [13:0] pin_sync_ff, nxt_pin_sync;
    logic [3:0] key_prev_ff, nxt_key_prev;
    isd_term_t term_s;
    isd_keys_t keys_s;
    isd_keys_t key_hit;

    always_comb begin
        nxt_pin_meta = {key_pins, term_pins};
        nxt_pin_sync = pin_meta_ff;
        nxt_key_prev = pin_sync_ff[13:10];
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_ff <= 14'h0000;
            pin_sync_ff <= 14'h0000;
            key_prev_ff <= 4'h0;
        end else begin
            pin_meta_ff <= nxt_pin_meta;
            pin_sync_ff <= nxt_pin_sync;
            key_prev_ff <= nxt_key_prev;
        end
    end

    // Press pulses on the rising edge of each synchronised key
    assign term_s = isd_term_t'(pin_sync_ff[9:0]);
    assign keys_s = isd_keys_t'(pin_sync_ff[13:10]);
    assign key_hit = isd_keys_t'(pin_sync_ff[13:10] & ~key_prev_ff);

    // Software registers: scope, hex page select, link command word
    logic [1:0] scope_ff, nxt_scope;
    logic hex_out_ff, nxt_hex_out;
    logic [15:0] link_cmd_ff, nxt_link_cmd;
    logic scope_full;

    always_comb begin
        nxt_scope = scope_ff;
        nxt_hex_out = hex_out_ff;
        nxt_link_cmd = link_cmd_ff;
        if (reg_wr && reg_addr == `ISD_OFF_CTRL) begin
            nxt_scope = reg_wdata[`ISD_CTRL_SCOPE_LSB +: 2];
            nxt_hex_out = reg_wdata[`ISD_CTRL_HEXOUT_BIT];
        end
        if (reg_wr && reg_addr == `ISD_OFF_LINK) begin
            nxt_link_cmd = reg_wdata[15:0] & `ISD_LINK_MASK; // Unused bits stay zero
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scope_ff <= `ISD_SCOPE_RESET;
            hex_out_ff <= `ISD_HEXOUT_RESET;
            link_cmd_ff <= `ISD_LINK_RESET;
        end else begin
            scope_ff <= nxt_scope;
            hex_out_ff <= nxt_hex_out;
            link_cmd_ff <= nxt_link_cmd;
        end
    end
    assign scope_full = (scope_ff == `ISD_SCOPE_FULL);

    // Operator menu walk; program key opens the menu, then backs out; function key enters, and leaves the data page
    isd_state_t state_ff, nxt_state;
    logic [2:0] menu_idx_ff, nxt_menu_idx;
    isd_item_t item_ff, nxt_item;
    logic hex_mode_ff, nxt_hex_mode;

    always_comb begin
        nxt_state = state_ff;
        nxt_menu_idx = menu_idx_ff;
        nxt_item = item_ff;
        nxt_hex_mode = hex_mode_ff;
        unique case (state_ff)
            ST_RUN: begin
                if (key_hit.prog) begin
                    nxt_state = ST_MENU;
                end
            end
            ST_MENU: begin
                if (key_hit.prog) begin
                    nxt_state = ST_RUN;
                end else if (!scope_full) begin
                    nxt_menu_idx = `ISD_MENU_FUNC;
                end else if (key_hit.func && menu_idx_ff == `ISD_MENU_IO) begin
                    nxt_state = ST_LIST;
                end else if (key_hit.up) begin
                    nxt_menu_idx = menu_idx_ff + 3'h1;
                end else if (key_hit.down) begin
                    nxt_menu_idx = menu_idx_ff - 3'h1;
                end
            end
            ST_LIST: begin
                if (key_hit.prog || !scope_full) begin
                    nxt_state = ST_MENU;
                end else if (key_hit.func) begin
                    nxt_state = ST_DATA;
                end else if (key_hit.up || key_hit.down) begin
                    nxt_item = key_hit.up // Wraps at both ends of the item list
                        ? ((item_ff == IT_PG) ? IT_TERM : isd_item_t'(item_ff + 2'h1))
                        : ((item_ff == IT_TERM) ? IT_PG : isd_item_t'(item_ff - 2'h1));
                end
            end
            ST_DATA: begin
                if (key_hit.prog || key_hit.func || !scope_full) begin
                    nxt_state = ST_LIST;
                end else if ((key_hit.up || key_hit.down) && item_ff != IT_PG) begin
                    nxt_hex_mode = !hex_mode_ff;
                end
            end
        endcase
    end

    // Power-up lands in running mode with segment display chosen
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_RUN;
            menu_idx_ff <= `ISD_MENU_FUNC;
            item_ff <= IT_TERM;
            hex_mode_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            menu_idx_ff <= nxt_menu_idx;
            item_ff <= nxt_item;
            hex_mode_ff <= nxt_hex_mode;
        end
    end

    // Input and output status words in hex bit layout
    logic [15:0] phys_in_word;
    logic [15:0] in_word;
    logic [15:0] out_word;
    logic [15:0] hex_word;
    logic [23:0] pg_quot;
    logic [15:0] pg_word;
    logic [15:0] glyph_word;
    logic [31:0] glyph_segs;

    assign phys_in_word = {9'h000, term_s.general_input_5, term_s.general_input_4,
        term_s.general_input_3, term_s.general_input_2, term_s.general_input_1,
        term_s.reverse_run_input, term_s.forward_run_input};
    assign in_word = (item_ff == IT_LINK) ? link_cmd_ff : phys_in_word;
    assign out_word = {7'h00, term_s.relay_contact_output, 6'h00,
        term_s.transistor_output_2, term_s.transistor_output_1};
    assign hex_word = hex_out_ff ? out_word : in_word;

    // Constant divide; saturates rather than wrap past four digits
    assign pg_quot = pulse_generator_feedback_rate / `ISD_PG_DIVISOR;
    assign pg_word = (pg_quot > `ISD_PG_MAX) ? 16'hFFFF : pg_quot[15:0];

    // Word handed to the glyph decoders in each menu state
    always_comb begin
        glyph_word = hex_word;
        unique case (state_ff)
            ST_RUN: glyph_word = hex_word;
            ST_MENU: glyph_word = {13'h0000, menu_idx_ff};
            ST_LIST: glyph_word = {`ISD_MENU_GLYPH_HI, 4'h0, (item_ff == IT_LINK) ? `ISD_CODE_LINK
                : (item_ff == IT_PG) ? `ISD_CODE_PG : `ISD_CODE_TERM};
            ST_DATA: glyph_word = (item_ff == IT_PG) ? pg_word : hex_word;
        endcase
    end

    // One decoder per digit
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_glyph
            isd_glyph u_glyph (
                .nibble(glyph_word[4 * gi +: 4]),
                .segs(glyph_segs[8 * gi +: 8])
            );
        end
    endgenerate

    // Display register, rebuilt every cycle so no change is missed
    isd_disp_t led_ff, nxt_led;
    isd_disp_t seg_view;
    logic inputs_off;

    assign inputs_off = (in_word == 16'h0000);

    always_comb begin
        seg_view.digit1 = {1'b0, in_word[6:0]};
        seg_view.digit2 = {in_word[15:13], 5'h00};
        seg_view.digit3 = {6'h00, out_word[1:0]};
        seg_view.digit4 = {7'h00, out_word[8]};
        if (inputs_off) begin
            seg_view = isd_disp_t'(seg_view | {4{`ISD_SEG_DASH}});
        end
    end
    always_comb begin
        nxt_led = isd_disp_t'(glyph_segs);
        unique case (state_ff)
            ST_RUN: nxt_led = '{`ISD_SEG_BLANK, `ISD_SEG_BLANK, `ISD_SEG_BLANK,
                `ISD_SEG_BLANK};
            ST_MENU: nxt_led = isd_disp_t'(glyph_segs);
            ST_LIST: begin
                nxt_led = isd_disp_t'(glyph_segs);
                nxt_led.digit3 = `ISD_SEG_UNDER;
            end
            ST_DATA: nxt_led = (item_ff != IT_PG && !hex_mode_ff) ? seg_view
                : isd_disp_t'(glyph_segs);
        endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            led_ff <= '{`ISD_SEG_BLANK, `ISD_SEG_BLANK, `ISD_SEG_BLANK, `ISD_SEG_BLANK};
        end else begin
            led_ff <= nxt_led;
        end
    end
    assign led = led_ff;

    // Read data stand only in the cycle after the strobe
    logic [31:0] rdata_ff, nxt_rdata;

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                `ISD_OFF_CTRL: nxt_rdata = {29'h0000_0000, hex_out_ff, scope_ff};
                `ISD_OFF_LINK: nxt_rdata = {16'h0000, link_cmd_ff};
                `ISD_OFF_STATUS: nxt_rdata = {24'h00_0000, hex_mode_ff, item_ff,
                    menu_idx_ff, state_ff};
                `ISD_OFF_DISPLAY: nxt_rdata = led_ff;
                `ISD_OFF_PGRATE: nxt_rdata = {8'h00, pulse_generator_feedback_rate};
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end
    assign reg_rdata = rdata_ff;

    // Checks on the display contents and menu walk
    logic data_seg;
    logic data_hex;
    assign data_seg = (state_ff == ST_DATA) && (item_ff != IT_PG) && !hex_mode_ff;
    assign data_hex = (state_ff == ST_DATA) && (item_ff != IT_PG) && hex_mode_ff;

    hex_glyph_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        (data_hex && !hex_out_ff && item_ff == IT_TERM && in_word == 16'h0005)
        |=> (led_ff == {`ISD_GLYPH_0, `ISD_GLYPH_0, `ISD_GLYPH_0, `ISD_GLYPH_5}))
        else $error("hex glyphs wrong for input word 0005");
    seg_inputs_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        (data_seg && !inputs_off) |=> (led_ff.digit1 == {1'b0, $past(in_word[6:0])}))
        else $error("rightmost digit does not follow inputs");
    seg_outputs_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        data_seg |=> (led_ff.digit3[1:0] == $past(out_word[1:0])))
        else $error("third digit does not follow transistor outputs");
    seg_relay_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        data_seg |=> (led_ff.digit4[0] == $past(out_word[8])))
        else $error("leftmost digit does not follow relay");
    dash_row_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        (data_seg && inputs_off)
        |=> (led_ff.digit1[6] && led_ff.digit2[6] && led_ff.digit3[6] && led_ff.digit4[6]))
        else $error("dash row missing with all inputs off");
    link_cmds_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        (data_seg && item_ff == IT_LINK) |=> (led_ff.digit2[7:5] == $past(link_cmd_ff[15:13])))
        else $error("link commands not on second digit");
    mode_toggle_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        ((state_ff == ST_DATA) && item_ff != IT_PG && key_hit.up && !key_hit.prog
        && !key_hit.func && scope_full) |=> (hex_mode_ff != $past(hex_mode_ff)))
        else $error("up key did not toggle display method");
    link_source_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        (data_hex && !hex_out_ff && item_ff == IT_LINK && link_cmd_ff[3:0] == 4'h0
        && phys_in_word[3:0] == 4'hF) |=> (led_ff.digit1 == `ISD_GLYPH_0))
        else $error("link item shows physical terminals");
    scope_gate_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        ((state_ff == ST_MENU) && !scope_full) |=> (state_ff != ST_LIST) [*2])
        else $error("I/O checking reached without full menu");
    pg_scale_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        ((state_ff == ST_DATA) && item_ff == IT_PG && pulse_generator_feedback_rate == 24'h0007D0)
        |=> (led_ff.digit1 == `ISD_GLYPH_2 && led_ff.digit2 == `ISD_GLYPH_0))
        else $error("pulse rate not divided by 1000");
    prog_key_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        ((state_ff == ST_RUN) && key_hit.prog) |=> (state_ff == ST_MENU))
        else $error("program key did not open the menu");
    hex_outputs_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        (data_hex && hex_out_ff && out_word == 16'h0101)
        |=> (led_ff == {`ISD_GLYPH_0, `ISD_GLYPH_1, `ISD_GLYPH_0, `ISD_GLYPH_1}))
        else $error("output word layout wrong");

endmodule

//--- verif/isd_panel_model.sv
`timescale 1ns/100ps
module isd_panel_model (
    input wire logic clk,
    output isd_pkg::isd_term_t term_pins,
    output isd_pkg::isd_keys_t key_pins
);
    import isd_pkg::*;

    // Contacts open and keys released at power-up
    initial begin
        term_pins = '0;
        key_pins = '0;
    end

    // One key held for a chosen span, then released long enough to count again
    task automatic press(input int k, input int hold);
        @(posedge clk);
        key_pins <= isd_keys_t'(4'h1 << k);
        repeat (hold) @(posedge clk);
        key_pins <= '0;
        repeat (6) @(posedge clk);
    endtask

    // Contacts switch by nonblocking update on a clock edge, in step with the key drives
    task automatic set_terms(input isd_term_t t);
        @(posedge clk);
        term_pins <= t;
    endtask
endmodule

//--- verif/isd_display_tb.sv
`timescale 1ns/100ps
module isd_display_tb;
    import isd_pkg::*;
    localparam int K_PROG = 3;
    localparam int K_UP = 2;
    localparam int K_DN = 1;
    localparam int K_FN = 0;
    localparam logic [7:0] GL [16] = '{8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66, 8'h6D, 8'h7D, 8'h07,
        8'h7F, 8'h6F, 8'h77, 8'h7C, 8'h39, 8'h5E, 8'h79, 8'h71};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    isd_term_t term_pins;
    isd_keys_t key_pins;
    logic [23:0] rate = 24'h000000;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    isd_disp_t led;
    int error_cnt = 0;
    int checked = 0;
    int seed = 80;
    logic [9:0] t;
    logic [15:0] lk;

    isd_display isd_display_i (.clk(clk), .rst_n(rst_n), .term_pins(term_pins),
        .key_pins(key_pins), .pulse_generator_feedback_rate(rate), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .led(led));
    isd_panel_model isd_panel_model_i (.clk(clk), .term_pins(term_pins), .key_pins(key_pins));

    // 25 MHz clock
    always #20 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("errors=%0d checks=%0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Single-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe, zero after that
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
        @(posedge clk);
        #1 chk(reg_rdata, 32'h00000000);
    endtask

    // Random hold span, so both quick taps and long presses occur
    task automatic key(input int k);
        isd_panel_model_i.press(k, 2 + ({$random(seed)} % 5));
    endtask

    task automatic settle;
        repeat (4) @(posedge clk);
        #1;
    endtask

    function automatic logic [31:0] seg_exp(logic [9:0] tp, logic [15:0] l, logic lnk);
        logic [6:0] in;
        logic [31:0] r;
        in = lnk ? l[6:0] : tp[6:0];
        r = {7'h00, tp[9], 6'h00, tp[8:7], (lnk ? {l[15:13], 5'h00} : 8'h00), 1'b0, in};
        if (in == 7'h00)
            r = r | 32'h40404040;
        return r;
    endfunction

    function automatic logic [31:0] hex_exp(logic [15:0] w);
        return {GL[w[15:12]], GL[w[11:8]], GL[w[7:4]], GL[w[3:0]]};
    endfunction

    // Hang guard sized well beyond the whole sequence
    initial begin
        #(40 * 40000);
        error_cnt++;
        complete_run;
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        settle;
        chk(led, 32'h00000000);
        rd(8'h08, 32'h00000000);
        rd(8'h00, 32'h00000000);
        // Limited menu scope keeps the checking menu out of reach
        key(K_PROG);
        rd(8'h08, 32'h00000001);
        repeat (4) key(K_UP);
        key(K_FN);
        rd(8'h08, 32'h00000001);
        wr(8'h00, 32'h00000002);
        rd(8'h00, 32'h00000002);
        repeat (4) key(K_UP);
        rd(8'h08, 32'h00000011);
        key(K_FN);
        key(K_FN);
        rd(8'h08, 32'h00000012);
        // Segment page: corners first, then random contacts
        for (int i = 0; i < 24; i++) begin
            t = (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : 10'($random(seed));
            isd_panel_model_i.set_terms(t);
            settle;
            chk(led, seg_exp(t, 16'h0000, 1'b0));
        end
        key(K_UP);
        rd(8'h08, 32'h00000092);
        for (int i = 0; i < 24; i++) begin
            // Relay plus first transistor output also lands on the output page
            t = (i == 0) ? 10'h005 : (i == 1 || i == 12) ? 10'h281 : 10'($random(seed));
            if (i == 12)
                wr(8'h00, 32'h00000006);
            isd_panel_model_i.set_terms(t);
            settle;
            if (i < 12)
                chk(led, hex_exp({9'h000, t[6:0]}));
            else
                chk(led, hex_exp({7'h00, t[9], 6'h00, t[8:7]}));
        end
        key(K_DN);
        rd(8'h08, 32'h00000012);
        wr(8'h00, 32'h00000002);
        // Commanded word: unmapped bits never stick
        wr(8'h04, 32'h0000FFFF);
        rd(8'h04, 32'h0000E07F);
        key(K_FN);
        key(K_UP);
        key(K_FN);
        rd(8'h08, 32'h00000032);
        for (int i = 0; i < 10; i++) begin
            lk = 16'($random(seed)) | 16'h0001;
            t = 10'($random(seed));
            wr(8'h04, {16'h0000, lk});
            isd_panel_model_i.set_terms(t);
            settle;
            chk(led, seg_exp(t, lk & 16'hE07F, 1'b1));
        end
        key(K_UP);
        rd(8'h08, 32'h000000B2);
        // Commanded low nibble clear while the first four physical inputs are closed
        wr(8'h04, 32'h00002000);
        isd_panel_model_i.set_terms(10'h00F);
        settle;
        chk(led, hex_exp(16'h2000));
        rd(8'h0C, hex_exp(16'h2000));
        key(K_DN);
        // Encoder rate item, code 15 on the list
        key(K_PROG);
        key(K_UP);
        key(K_FN);
        rd(8'h08, 32'h00000052);
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            rate <= (i == 0) ? 24'd999 : (i == 1) ? 24'd1000 : (i == 2) ? 24'hFFFFFF
                : (i == 3) ? 24'd2000 : 24'($random(seed));
            settle;
            chk(led, hex_exp(16'(rate / 24'd1000)));
        end
        // Read-only and unmapped places
        wr(8'h10, 32'h00000000);
        rd(8'h10, {8'h00, rate});
        rd(8'h14, 32'h00000000);
        key(K_PROG);
        key(K_PROG);
        // Item and menu index are kept when backing out to running mode
        rd(8'h08, 32'h00000051);
        key(K_PROG);
        rd(8'h08, 32'h00000050);
        settle;
        chk(led, 32'h00000000);
        complete_run;
    end
endmodule
